/* rtl/ppm_port_mux.sv */
// port six (pins 3..0) and port seven pin logic with register slave
//
// What this block does
// - P6 pin3 direction bit selects in/out; capture-B and wakeup-3 always see pin.
// - P6 pin2 direction selects in/out; capture-A, timer-Y input, wakeup-2 see pin.
// - P6 pin1 drives compare-A output when enabled, else direction selects in/out.
// - Wakeup-1 always sees P6 pin1 level whatever its function.
// - P6 pin0 feeds free timer clock when external clock selected.
// - Timer-X input and wakeup-0 always see P6 pin0 level.
// - Each port-six pull-up is switched per bit by software.
// - Strength bit selects current specification of all port-six pull-ups.
// - Pull-up forced off while pin serves a peripheral output.
// - Pull-ups off in reset and hardware standby; else input, dir 0, control 1.
// - Port-seven level register always reads synchronised pin levels.
// - Writing the port-seven level address updates port-B direction instead.
// - Write-only port-seven direction: 1 output, 0 input, reset 0.
// - Port-seven output data resets to 0, always readable and writable.
// - P7 pin7 drives timer-X extended output when selected and field nonzero.
// - P7 pin6 drives timer-Y output when enabled and field nonzero.
// - Port-six read gives data for bits with direction 1, pin levels for bits with direction 0.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [3:0] i_p6_pin,
  output logic [3:0] o_p6_out,
  output logic [3:0] o_p6_oe,
  output logic [3:0] o_p6_pullup_en,
  output logic o_pullup_strength_select,
  input wire logic [7:0] i_p7_pin,
  output logic [7:0] o_p7_out,
  output logic [7:0] o_p7_oe,
  output logic [7:0] o_portb_direction,
  input wire logic i_compare_a_output,
  input wire logic i_timer_x_extended_output,
  input wire logic i_timer_y_output,
  output ppm_pkg::ppm_periph_in_type o_periph_in
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0] p6_data;
  logic [3:0] p6_direction;
  logic [3:0] p6_pullup_control;
  logic [7:0] p6_config;
  logic [7:0] port7_direction;
  logic [7:0] port7_output_data;
  logic [7:0] periph_ctrl;
  logic [7:0] portb_direction;
  logic [7:0] rdata;
  logic [3:0] next_p6_data;
  logic [3:0] next_p6_direction;
  logic [3:0] next_p6_pullup_control;
  logic [7:0] next_p6_config;
  logic [7:0] next_port7_direction;
  logic [7:0] next_port7_output_data;
  logic [7:0] next_periph_ctrl;
  logic [7:0] next_portb_direction;
  logic [7:0] next_rdata;

  logic [3:0] p6_sync;
  logic [7:0] p7_sync;
  logic [3:0] p6_is_input;
  logic [3:0] p6_periph_sel;
  logic [3:0] p6_periph_out;
  logic [7:0] p7_periph_sel;
  logic [7:0] p7_periph_out;
  ppm_pkg::ppm_periph_type periph;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ppm_sync #(.W(4)) u_sync6 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_p6_pin),
    .o_sync(p6_sync)
  );

  ppm_sync #(.W(8)) u_sync7 (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_async(i_p7_pin),
    .o_sync(p7_sync)
  );

  // ----------------------------------------------------------------
  // peripheral control decode
  // ----------------------------------------------------------------
  always_comb begin
    periph.compare_a_output_enable = periph_ctrl[ppm_pkg::BIT_COMPARE_A_OE];
    periph.clock_select = {periph_ctrl[ppm_pkg::BIT_CLK_SEL_HI],
                           periph_ctrl[ppm_pkg::BIT_CLK_SEL_LO]};
    periph.extended_output_select = periph_ctrl[ppm_pkg::BIT_EXT_OUT_SEL];
    periph.timer_y_output_enable = periph_ctrl[ppm_pkg::BIT_TIMER_Y_OE];
    periph.output_select_field = periph_ctrl[ppm_pkg::LSB_OUTPUT_SELECT +: 4];
  end

  // ----------------------------------------------------------------
  // pin function select
  // ----------------------------------------------------------------
  always_comb begin
    p6_periph_sel = 4'h0;
    p6_periph_out = 4'h0;
    p6_periph_sel[1] = periph.compare_a_output_enable;
    p6_periph_out[1] = i_compare_a_output;
    p7_periph_sel = 8'h00;
    p7_periph_out = 8'h00;
    p7_periph_sel[7] = periph.extended_output_select & (|periph.output_select_field);
    p7_periph_out[7] = i_timer_x_extended_output;
    p7_periph_sel[6] = periph.timer_y_output_enable & (|periph.output_select_field);
    p7_periph_out[6] = i_timer_y_output;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_p6
      ppm_pin_cell u_cell (
        .i_direction(p6_direction[g]),
        .i_data(p6_data[g]),
        .i_periph_sel(p6_periph_sel[g]),
        .i_periph_out(p6_periph_out[g]),
        .o_out(o_p6_out[g]),
        .o_oe(o_p6_oe[g]),
        .o_is_input(p6_is_input[g])
      );
    end
    for (g = 0; g < 8; g++) begin : g_p7
      ppm_pin_cell u_cell (
        .i_direction(port7_direction[g]),
        .i_data(port7_output_data[g]),
        .i_periph_sel(p7_periph_sel[g]),
        .i_periph_out(p7_periph_out[g]),
        .o_out(o_p7_out[g]),
        .o_oe(o_p7_oe[g]),
        .o_is_input()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // peripheral inputs and pull-ups
  // ----------------------------------------------------------------
  always_comb begin
    o_periph_in.capture_b_input = p6_sync[3];
    o_periph_in.capture_a_input = p6_sync[2];
    o_periph_in.timer_y_ext_input = p6_sync[2];
    o_periph_in.timer_x_ext_input = p6_sync[0];
    // clock only passes when the free timer asks for an external source
    o_periph_in.free_timer_clock_input =
      (periph.clock_select == ppm_pkg::CLK_SEL_EXTERNAL) & p6_sync[0];
    o_periph_in.key_wakeup_in = p6_sync;
  end

  // hardware standby comes from a software-visible bit here since the block has no mode pin;
  // the gate is a plain AND so reset (regs at zero) also forces every pull-up off
  assign o_p6_pullup_en = p6_is_input & ~p6_direction & p6_pullup_control
                          & {4{~p6_config[ppm_pkg::BIT_HW_STANDBY]}};
  assign o_pullup_strength_select = p6_config[ppm_pkg::BIT_PULLUP_STRENGTH];
  assign o_portb_direction = portb_direction;

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_comb begin
    next_p6_data = p6_data;
    next_p6_direction = p6_direction;
    next_p6_pullup_control = p6_pullup_control;
    next_p6_config = p6_config;
    next_port7_direction = port7_direction;
    next_port7_output_data = port7_output_data;
    next_periph_ctrl = periph_ctrl;
    next_portb_direction = portb_direction;
    next_rdata = ppm_pkg::READ_UNMAPPED;
    if (i_wr) begin
      if (hit(i_addr, ppm_pkg::OFS_P6_DATA)) begin
        next_p6_data = i_wdata[3:0];
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_DIRECTION)) begin
        next_p6_direction = i_wdata[3:0];
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_PULLUP)) begin
        next_p6_pullup_control = i_wdata[3:0];
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_CONFIG)) begin
        next_p6_config = i_wdata;
      end
      if (hit(i_addr, ppm_pkg::OFS_P7_PIN_LEVELS)) begin
        next_portb_direction = i_wdata;
      end
      if (hit(i_addr, ppm_pkg::OFS_P7_DIRECTION)) begin
        next_port7_direction = i_wdata;
      end
      if (hit(i_addr, ppm_pkg::OFS_P7_OUTPUT_DATA)) begin
        next_port7_output_data = i_wdata;
      end
      if (hit(i_addr, ppm_pkg::OFS_PERIPH_CTRL)) begin
        next_periph_ctrl = i_wdata;
      end
    end
    if (i_rd) begin
      if (hit(i_addr, ppm_pkg::OFS_P6_DATA)) begin
        next_rdata = {4'h0, (p6_direction & p6_data) | (~p6_direction & p6_sync)};
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_DIRECTION)) begin
        next_rdata = {4'h0, p6_direction};
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_PULLUP)) begin
        next_rdata = {4'h0, p6_pullup_control};
      end
      if (hit(i_addr, ppm_pkg::OFS_P6_CONFIG)) begin
        next_rdata = p6_config;
      end
      if (hit(i_addr, ppm_pkg::OFS_P7_PIN_LEVELS)) begin
        next_rdata = p7_sync;
      end
      // direction is write-only and reads as zero
      if (hit(i_addr, ppm_pkg::OFS_P7_OUTPUT_DATA)) begin
        next_rdata = port7_output_data;
      end
      if (hit(i_addr, ppm_pkg::OFS_PERIPH_CTRL)) begin
        next_rdata = periph_ctrl;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      p6_data <= 4'h0;
      p6_direction <= 4'h0;
      p6_pullup_control <= 4'h0;
      p6_config <= ppm_pkg::RST_ZERO;
      port7_direction <= ppm_pkg::RST_ZERO;
      port7_output_data <= ppm_pkg::RST_ZERO;
      periph_ctrl <= ppm_pkg::RST_ZERO;
      portb_direction <= ppm_pkg::RST_ZERO;
      rdata <= ppm_pkg::RST_ZERO;
    end else begin
      p6_data <= next_p6_data;
      p6_direction <= next_p6_direction;
      p6_pullup_control <= next_p6_pullup_control;
      p6_config <= next_p6_config;
      port7_direction <= next_port7_direction;
      port7_output_data <= next_port7_output_data;
      periph_ctrl <= next_periph_ctrl;
      portb_direction <= next_portb_direction;
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
endmodule // ppm_port_mux
`default_nettype wire

/* inc/ppm_pkg.sv */
// package: register map, field positions and carrier types of the port pin mux
package ppm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [3:0] OFS_P6_DATA = 4'h0;
  localparam logic [3:0] OFS_P6_DIRECTION = 4'h1;
  localparam logic [3:0] OFS_P6_PULLUP = 4'h2;
  localparam logic [3:0] OFS_P6_CONFIG = 4'h3;
  localparam logic [3:0] OFS_P7_PIN_LEVELS = 4'h4;
  localparam logic [3:0] OFS_P7_DIRECTION = 4'h5;
  localparam logic [3:0] OFS_P7_OUTPUT_DATA = 4'h6;
  localparam logic [3:0] OFS_PERIPH_CTRL = 4'h7;
  localparam logic [3:0] OFS_PORTB_DIRECTION = 4'h8;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  // p6 config fields
  localparam int BIT_PULLUP_STRENGTH = 5;
  localparam int BIT_HW_STANDBY = 0;
  // peripheral control fields
  localparam int BIT_COMPARE_A_OE = 0;
  localparam int BIT_CLK_SEL_LO = 1;
  localparam int BIT_CLK_SEL_HI = 2;
  localparam int BIT_EXT_OUT_SEL = 3;
  localparam int BIT_TIMER_Y_OE = 4;
  localparam int LSB_OUTPUT_SELECT = 4;
  localparam logic [1:0] CLK_SEL_EXTERNAL = 2'h3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef struct packed {
    logic compare_a_output_enable;
    logic [1:0] clock_select;
    logic extended_output_select;
    logic timer_y_output_enable;
    logic [3:0] output_select_field;
  } ppm_periph_type;

  typedef struct packed {
    logic capture_b_input;
    logic capture_a_input;
    logic timer_y_ext_input;
    logic timer_x_ext_input;
    logic free_timer_clock_input;
    logic [3:0] key_wakeup_in;
  } ppm_periph_in_type;
endpackage

/* rtl/ppm_sync.sv */
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ppm_sync #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;
  logic [W-1:0] next_level;

  // a change counts once stages two and three agree; stage one feeds only stage two
  always_comb begin
    next_level = level;
    for (int i = 0; i < W; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level <= '0;
    end else begin
      meta <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
      level <= next_level;
    end
  end

  assign o_sync = level;
endmodule // ppm_sync
`default_nettype wire

/* rtl/ppm_pin_cell.sv */
// one pin: function mux between general output and peripheral output
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_cell (
  input wire logic i_direction,
  input wire logic i_data,
  input wire logic i_periph_sel,
  input wire logic i_periph_out,
  output logic o_out,
  output logic o_oe,
  output logic o_is_input
);
  // a peripheral output overrides the direction bit entirely
  assign o_out = i_periph_sel ? i_periph_out : i_data;
  assign o_oe = i_periph_sel | i_direction;
  assign o_is_input = ~o_oe;
endmodule // ppm_pin_cell
`default_nettype wire

/* tb/ppm_pin_model.sv */
// board model: external drivers, pull-ups and floating lines on a port
`timescale 1ns/1ps
`default_nettype none
module ppm_pin_model #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic [W-1:0] i_out,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_pullup,
  input wire logic [W-1:0] i_ext_en,
  input wire logic [W-1:0] i_ext_val,
  output logic [W-1:0] o_pin
);
  logic [W-1:0] flip = '0;
  // a released line with no pull-up wanders, so a stale level never reads as valid
  always @(posedge i_mclk) begin
    flip <= ~flip;
  end
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_pin[k] = i_oe[k] ? i_out[k] : (i_ext_en[k] ? i_ext_val[k] : (i_pullup[k] | flip[k]));
    end
  end
endmodule // ppm_pin_model
`default_nettype wire

/* tb/ppm_port_mux_assertions.sv */
// checker: port-level assertions of the port pin mux
`timescale 1ns/1ps
`default_nettype none
module ppm_port_mux_assertions (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [3:0] i_p6_pin,
  input wire logic [3:0] o_p6_out,
  input wire logic [3:0] o_p6_oe,
  input wire logic [3:0] o_p6_pullup_en,
  input wire logic o_pullup_strength_select,
  input wire logic [7:0] i_p7_pin,
  input wire logic [7:0] o_p7_out,
  input wire logic [7:0] o_p7_oe,
  input wire logic [7:0] o_portb_direction,
  input wire logic i_compare_a_output,
  input wire logic i_timer_x_extended_output,
  input wire logic i_timer_y_output,
  input wire ppm_pkg::ppm_periph_in_type o_periph_in
);
  // ----------------------------------------
  // shadow registers rebuilt from bus writes
  // ----------------------------------------
  logic [7:0] dat6, dir6, pu6, cfg, dir7, odr7, ctl, pbd;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {dat6, dir6, pu6, cfg, dir7, odr7, ctl, pbd} <= '0;
    end else if (i_wr) begin
      case (i_addr)
        4'h0: dat6 <= i_wdata;
        4'h1: dir6 <= i_wdata;
        4'h2: pu6 <= i_wdata;
        4'h3: cfg <= i_wdata;
        4'h4: pbd <= i_wdata;
        4'h5: dir7 <= i_wdata;
        4'h6: odr7 <= i_wdata;
        4'h7: ctl <= i_wdata;
        default: ;
      endcase
    end
  end
  wire logic sel7 = ctl[3] && (ctl[7:4] != 4'h0);
  wire logic sel6 = ctl[4] && (ctl[7:4] != 4'h0);
  wire logic [3:0] per6 = {2'h0, ctl[0], 1'h0};
  wire logic [3:0] out6 = {dat6[3:2], ctl[0] ? i_compare_a_output : dat6[1], dat6[0]};
  wire logic [7:0] out7 = {sel7 ? i_timer_x_extended_output : odr7[7],
    sel6 ? i_timer_y_output : odr7[6], odr7[5:0]};
  wire logic [3:0] rd6 = (dat6[3:0] & dir6[3:0]) | (i_p6_pin & ~dir6[3:0]);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  p6_drive_a: assert property (
    o_p6_oe == (dir6[3:0] | per6) && ((o_p6_out ^ out6) & o_p6_oe) == 4'h0)
    else $error("port six drive mismatch");
  pullup_gate_a: assert property (
    o_p6_pullup_en == (pu6[3:0] & ~dir6[3:0] & ~per6 & {4{~cfg[0]}}))
    else $error("pull-up enable mismatch");
  strength_sel_a: assert property (o_pullup_strength_select == cfg[5])
    else $error("pull-up strength mismatch");
  p7_drive_a: assert property (
    o_p7_oe == {sel7 | dir7[7], sel6 | dir7[6], dir7[5:0]} && ((o_p7_out ^ out7) & o_p7_oe) == 8'h00)
    else $error("port seven drive mismatch");
  portb_dir_a: assert property (o_portb_direction == pbd)
    else $error("port b direction mismatch");
  odr_read_a: assert property (i_rd && i_addr == 4'h6 |=> o_rdata == $past(odr7))
    else $error("output data read mismatch");
  wo_read_a: assert property (i_rd && i_addr == 4'h5 |=> o_rdata == 8'h00)
    else $error("write-only register read not zero");
  idle_read_a: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  level_read_a: assert property (
    $stable(i_p7_pin) [*6] ##0 (i_rd && i_addr == 4'h4) |=> o_rdata == $past(i_p7_pin))
    else $error("pin level read mismatch");
  p6_read_a: assert property (
    $stable(i_p6_pin) [*6] ##0 (i_rd && i_addr == 4'h0) |=> o_rdata[3:0] == $past(rd6))
    else $error("port six read mismatch");
  sync_in_a: assert property ($stable(i_p6_pin) [*6] ##0 $stable(ctl) |->
    o_periph_in == {i_p6_pin[3], i_p6_pin[2], i_p6_pin[2], i_p6_pin[0],
      (ctl[2:1] == 2'h3) & i_p6_pin[0], i_p6_pin})
    else $error("peripheral input mismatch");
endmodule // ppm_port_mux_assertions
bind ppm_port_mux ppm_port_mux_assertions chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_p6_pin(i_p6_pin), .o_p6_out(o_p6_out), .o_p6_oe(o_p6_oe),
  .o_p6_pullup_en(o_p6_pullup_en), .o_pullup_strength_select(o_pullup_strength_select),
  .i_p7_pin(i_p7_pin), .o_p7_out(o_p7_out), .o_p7_oe(o_p7_oe),
  .o_portb_direction(o_portb_direction), .i_compare_a_output(i_compare_a_output),
  .i_timer_x_extended_output(i_timer_x_extended_output),
  .i_timer_y_output(i_timer_y_output), .o_periph_in(o_periph_in));
`default_nettype wire

/* tb/test_port_pin_function_mux.sv */
// testbench: registers, pin mux, pull-ups and synchronised inputs of the port pin mux
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_mux;
  logic i_mclk = 1'h0;
  logic i_rst_n = 1'h0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic i_compare_a_output = 1'h0;
  logic i_timer_x_extended_output = 1'h0;
  logic i_timer_y_output = 1'h0;
  logic [3:0] e6en = 4'h0;
  logic [3:0] e6v = 4'h0;
  logic [7:0] e7en = 8'h00;
  logic [7:0] e7v = 8'h00;
  logic [7:0] o_rdata, i_p7_pin, o_p7_out, o_p7_oe, o_portb_direction;
  logic [3:0] i_p6_pin, o_p6_out, o_p6_oe, o_p6_pullup_en;
  logic o_pullup_strength_select;
  ppm_pkg::ppm_periph_in_type o_periph_in;
  int err_count = 0;
  int n_checks = 0;
  always #5 i_mclk = ~i_mclk;
  ppm_port_mux dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_p6_pin(i_p6_pin), .o_p6_out(o_p6_out),
    .o_p6_oe(o_p6_oe), .o_p6_pullup_en(o_p6_pullup_en),
    .o_pullup_strength_select(o_pullup_strength_select), .i_p7_pin(i_p7_pin),
    .o_p7_out(o_p7_out), .o_p7_oe(o_p7_oe), .o_portb_direction(o_portb_direction),
    .i_compare_a_output(i_compare_a_output),
    .i_timer_x_extended_output(i_timer_x_extended_output),
    .i_timer_y_output(i_timer_y_output), .o_periph_in(o_periph_in));
  ppm_pin_model #(.W(4)) board6 (.i_mclk(i_mclk), .i_out(o_p6_out), .i_oe(o_p6_oe),
    .i_pullup(o_p6_pullup_en), .i_ext_en(e6en), .i_ext_val(e6v), .o_pin(i_p6_pin));
  ppm_pin_model #(.W(8)) board7 (.i_mclk(i_mclk), .i_out(o_p7_out), .i_oe(o_p7_oe),
    .i_pullup(8'h00), .i_ext_en(e7en), .i_ext_val(e7v), .o_pin(i_p7_pin));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    @(posedge i_mclk);
    i_wr <= 1'h0;
    #1;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'h1;
    @(posedge i_mclk);
    i_rd <= 1'h0;
    #1;
    chk(o_rdata & m, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_p7;
    chk(o_p7_oe, 8'h00);
    rd_chk(4'h6, 8'h00);
    wr(4'h5, 8'hFF);
    wr(4'h6, 8'hA5);
    chk(o_p7_oe, 8'hFF);
    chk(o_p7_out, 8'hA5);
    rd_chk(4'h6, 8'hA5);
    rd_chk(4'h5, 8'h00);
    wr(4'h4, 8'h3C);
    chk(o_portb_direction, 8'h3C);
    chk(o_p7_oe, 8'hFF);
    rd_chk(4'h4, 8'hA5);
    wr(4'h5, 8'h00);
    @(posedge i_mclk);
    e7en <= 8'hFF;
    e7v <= 8'h5A;
    repeat (8) @(posedge i_mclk);
    rd_chk(4'h4, 8'h5A);
    rd_chk(4'h6, 8'hA5);
    $display("port seven registers done");
  endtask
  task automatic t_tmr;
    logic [7:0] cv [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h28, 8'hE0};
    logic [1:0] ev [6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
    @(posedge i_mclk);
    i_timer_x_extended_output <= 1'h1;
    i_timer_y_output <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      wr(4'h7, cv[k]);
      chk({6'h00, o_p7_oe[7:6]}, {6'h00, ev[k]});
      chk({6'h00, o_p7_out[7:6] & o_p7_oe[7:6]}, {6'h00, ev[k]});
    end
    wr(4'h7, 8'h00);
    $display("port seven timer outputs done");
  endtask
  task automatic t_p6;
    @(posedge i_mclk);
    i_compare_a_output <= 1'h1;
    wr(4'h1, 8'h05);
    wr(4'h0, 8'h09);
    wr(4'h2, 8'h0F);
    chk({4'h0, o_p6_oe}, 8'h05);
    chk({4'h0, o_p6_out & o_p6_oe}, 8'h01);
    chk({4'h0, o_p6_pullup_en}, 8'h0A);
    wr(4'h7, 8'h01);
    chk({4'h0, o_p6_oe}, 8'h07);
    chk({4'h0, o_p6_out & o_p6_oe}, 8'h03);
    chk({4'h0, o_p6_pullup_en}, 8'h08);
    repeat (6) @(posedge i_mclk);
    rd_chk(4'h0, 8'h0B, 8'h0F);
    // pin one now output with compare-A driving 1 while its data bit is 0
    wr(4'h1, 8'h07);
    rd_chk(4'h0, 8'h09, 8'h0F);
    wr(4'h3, 8'h21);
    chk({7'h00, o_pullup_strength_select}, 8'h01);
    chk({4'h0, o_p6_pullup_en}, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    $display("port six mux and pull-ups done");
  endtask
  task automatic t_wake;
    logic [3:0] pv [2] = '{4'hA, 4'h5};
    wr(4'h7, 8'h07);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_mclk);
      e6en <= 4'hD;
      e6v <= pv[k];
      i_compare_a_output <= pv[k][1];
      repeat (6) @(posedge i_mclk);
      #1;
      chk({4'h0, o_periph_in.key_wakeup_in}, {4'h0, pv[k]});
      chk({3'h0, o_periph_in.capture_b_input, o_periph_in.capture_a_input,
        o_periph_in.timer_y_ext_input, o_periph_in.timer_x_ext_input,
        o_periph_in.free_timer_clock_input},
        {3'h0, pv[k][3], pv[k][2], pv[k][2], pv[k][0], pv[k][0]});
    end
    wr(4'h7, 8'h01);
    repeat (2) @(posedge i_mclk);
    #1;
    chk({7'h00, o_periph_in.free_timer_clock_input}, 8'h00);
    $display("synchronised inputs done");
  endtask
  task automatic t_rst;
    wr(4'h2, 8'h0F);
    wr(4'h5, 8'hC3);
    chk({4'h0, o_p6_pullup_en}, 8'h0D);
    chk(o_p7_oe, 8'hC3);
    @(posedge i_mclk);
    i_rst_n <= 1'h0;
    #1;
    chk({4'h0, o_p6_pullup_en}, 8'h00);
    chk(o_p7_oe, 8'h00);
    @(posedge i_mclk);
    i_rst_n <= 1'h1;
    #1;
    rd_chk(4'h6, 8'h00);
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    #1;
    t_p7;
    t_tmr;
    t_p6;
    t_wake;
    t_rst;
    end_sim;
  end
  // the run needs about a hundred cycles; this span is far beyond it
  initial begin
    #100000;
    err_count++;
    $display("wrong value at %0t: run hung", $time);
    end_sim;
  end
endmodule // test_port_pin_function_mux
`default_nettype wire
